/* File: include/mocfg_pkg.sv */
// Purpose: Shared constants for the hard-wired mask option configuration block.
// Assumes: One core clock tick equals one double-rate oscillator cycle.
// Notes: Option bit positions and the block's own register offsets live here.
// Contract
// - The watchdog times out after 8176 cycles when period select is 1, else 262,128.
// - The undervoltage inhibit circuit is off when its disable option is 1, on when 0.
// - Stop recovery lasts 32 cycles with short wake set and 4096 cycles with it clear.
// - A stop exit caused by the external reset always uses the long recovery delay.
// - With the stop enable option 1 the stop instruction runs, with 0 it is illegal.
// - The watchdog is held inactive when its disable option is 1 and runs when 0.
// - The interrupt pin pull-up is disconnected when its option is 1, connected when 0.
// - A two-bit option picks the undervoltage trip level, decoded by that logic itself.
// - All options are fixed at manufacture and nothing at run time can alter them.
// - Addresses fe08 and fe09 are reserved on ROM parts and flash registers otherwise.
package mocfg_pkg;

    localparam int MOCFG_ADDR_W = 16;
    localparam int MOCFG_DATA_W = 8;

    // Register byte addresses.
    localparam logic [15:0] MOCFG_ADDR_OPT_FIRST = 16'hfe1e;
    localparam logic [15:0] MOCFG_ADDR_OPT_SECOND = 16'hfe1f;
    localparam logic [15:0] MOCFG_ADDR_FLASH_CTRL = 16'hfe08;
    localparam logic [15:0] MOCFG_ADDR_FLASH_PROT = 16'hfe09;
    localparam logic [15:0] MOCFG_ADDR_STATUS = 16'hfe1c;
    localparam logic [15:0] MOCFG_ADDR_SERVICE = 16'hfe1d;

    // Bit positions in mask_option_first.
    localparam int MOCFG_BIT_WDT_DISABLE = 0;
    localparam int MOCFG_BIT_STOP_ENABLE = 1;
    localparam int MOCFG_BIT_SHORT_WAKE = 2;
    localparam int MOCFG_BIT_UV_DISABLE = 3;
    localparam int MOCFG_BIT_WDT_PERIOD = 4;

    // Bit positions in mask_option_second.
    localparam int MOCFG_BIT_TRIP_LO = 0;
    localparam int MOCFG_BIT_TRIP_HI = 1;
    localparam int MOCFG_BIT_PULLUP_OFF = 7;

    // Bit positions in the status register.
    localparam int MOCFG_BIT_ST_STOPPED = 0;
    localparam int MOCFG_BIT_ST_RECOVER = 1;
    localparam int MOCFG_BIT_ST_WDT_RUN = 2;
    localparam int MOCFG_BIT_ST_LONG_USED = 3;

    // Watchdog periods and stop recovery delays, in double-rate oscillator cycles.
    localparam int MOCFG_WDT_SHORT_CYC = 8176;
    localparam int MOCFG_WDT_LONG_CYC = 262128;
    localparam int MOCFG_WAKE_SHORT_CYC = 32;
    localparam int MOCFG_WAKE_LONG_CYC = 4096;
    localparam int MOCFG_WAKE_W = 13;

    localparam logic [7:0] MOCFG_ZERO_BYTE = 8'h00;

    // Stop sequencer states.
    typedef enum logic [2:0] {
        MOCFG_RUN = 3'b001,
        MOCFG_STOPPED = 3'b010,
        MOCFG_RECOVER = 3'b100
    } mocfg_stop_state_type;

endpackage

/* File: core/mocfg_stop_seq.sv */
// Purpose: Stop mode sequencer with selectable recovery delay.
// Assumes: Each clock edge is one double-rate oscillator cycle.
// Notes: The delay counter is idle outside recovery, as the clocks would be gated.
`timescale 1ns/1ps
`default_nettype none
module mocfg_stop_seq
    import mocfg_pkg::*;
(
    input wire logic core_clk, // Core clock.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic stop_go, // Accepted stop instruction, one-cycle pulse.
    input wire logic wake_irq, // Interrupt wake request, level.
    input wire logic wake_reset_pin, // External reset pin wake request, level.
    input wire logic short_wake_select, // Wired short wake option.
    output logic in_stop, // Clocks stopped.
    output logic in_recover, // Recovery delay running.
    output logic long_used, // Last recovery used the long delay.
    output logic wake_done // Recovery finished, one-cycle pulse.
);

    mocfg_stop_state_type state;
    mocfg_stop_state_type next_state;
    logic [MOCFG_WAKE_W-1:0] count;
    logic [MOCFG_WAKE_W-1:0] next_count;
    logic next_long_used;
    logic next_wake_done;

    ////////////////////////////////////////////////////////////////////////////
    // Next state. The reset pin is checked first so it can never pick the short delay.
    always_comb begin
        next_state = state;
        next_count = count;
        next_long_used = long_used;
        next_wake_done = 1'b0;
        unique case (state)
            MOCFG_RUN: begin
                if (stop_go) begin
                    next_state = MOCFG_STOPPED;
                end
            end
            MOCFG_STOPPED: begin
                if (wake_reset_pin) begin
                    next_state = MOCFG_RECOVER;
                    next_count = MOCFG_WAKE_W'(MOCFG_WAKE_LONG_CYC - 1);
                    next_long_used = 1'b1;
                end else if (wake_irq) begin
                    next_state = MOCFG_RECOVER;
                    if (short_wake_select) begin
                        next_count = MOCFG_WAKE_W'(MOCFG_WAKE_SHORT_CYC - 1);
                        next_long_used = 1'b0;
                    end else begin
                        next_count = MOCFG_WAKE_W'(MOCFG_WAKE_LONG_CYC - 1);
                        next_long_used = 1'b1;
                    end
                end
            end
            MOCFG_RECOVER: begin
                if (count == '0) begin
                    next_state = MOCFG_RUN;
                    next_wake_done = 1'b1;
                end else begin
                    next_count = count - MOCFG_WAKE_W'(1);
                end
            end
        endcase
    end

    // Registers only.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= MOCFG_RUN;
            count <= '0;
            long_used <= 1'b0;
            wake_done <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            long_used <= next_long_used;
            wake_done <= next_wake_done;
        end
    end

    assign in_stop = (state == MOCFG_STOPPED);
    assign in_recover = (state == MOCFG_RECOVER);

endmodule // mocfg_stop_seq
`default_nettype wire

/* File: core/mocfg_top.sv */
// Purpose: Mask option registers and the logic they steer.
// Assumes: core_clk is the double-rate oscillator clock; bus inputs are synchronous.
// Notes: Option values are parameters only, so no run-time path can change them.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module mocfg_top
    import mocfg_pkg::*;
#(
    parameter logic [7:0] OPT_FIRST = 8'h00, // Wired value of mask_option_first.
    parameter logic [7:0] OPT_SECOND = 8'h00, // Wired value of mask_option_second.
    parameter bit FLASH_PART = 1'b0, // 1 selects the flash variant decode.
    parameter int WDT_SHORT = MOCFG_WDT_SHORT_CYC, // Short watchdog period.
    parameter int WDT_LONG = MOCFG_WDT_LONG_CYC, // Long watchdog period.
    parameter int WDT_W = 18 // Watchdog counter width.
)(
    input wire logic core_clk, // Core clock, 25 MHz.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic [15:0] addr, // Register address.
    input wire logic [7:0] wdata, // Write data.
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    output logic [7:0] rdata, // Read data, valid the cycle after rd.
    output logic flash_ctrl_sel, // Flash control access select.
    output logic flash_prot_sel, // Flash protect-range access select.
    input wire logic [7:0] flash_rdata, // Read data from the flash registers.
    input wire logic stop_decode, // Core decoded a stop opcode, pulse.
    output logic stop_taken, // Stop instruction accepted, pulse.
    output logic illegal_opcode, // Stop decoded as illegal, pulse.
    input wire logic wake_irq, // Interrupt wake request.
    input wire logic wake_reset_pin, // External reset wake request.
    output logic in_stop, // Device in stop mode.
    output logic in_recover, // Stop recovery running.
    output logic wake_done, // Stop recovery finished, pulse.
    input wire logic watchdog_kick, // Watchdog service from the core, pulse.
    output logic watchdog_active, // Watchdog counting enabled.
    output logic watchdog_reset, // Watchdog timeout, pulse.
    output logic undervoltage_enable, // Undervoltage inhibit circuit enable.
    output logic [1:0] undervoltage_trip_select, // Trip level code.
    output logic ext_int_pullup_en // Interrupt pin pull-up connected.
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks.
    generate
        if (WDT_SHORT < 1 || WDT_LONG < 1) begin : g_bad_period
            $error("Watchdog periods must be at least one cycle.");
        end
        if (WDT_W < 2 || WDT_W > 31) begin : g_bad_width
            $error("Watchdog counter width out of range.");
        end else if (WDT_LONG > (1 << WDT_W) || WDT_SHORT > (1 << WDT_W)) begin : g_bad_fit
            $error("Watchdog period does not fit the counter.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Option decode. These are constants; no flop or bus path reaches them.
    logic opt_wdt_disable;
    logic opt_stop_enable;
    logic opt_short_wake;
    logic opt_uv_disable;
    logic opt_wdt_period;
    logic opt_pullup_off;

    assign opt_wdt_disable = OPT_FIRST[MOCFG_BIT_WDT_DISABLE];
    assign opt_stop_enable = OPT_FIRST[MOCFG_BIT_STOP_ENABLE];
    assign opt_short_wake = OPT_FIRST[MOCFG_BIT_SHORT_WAKE];
    assign opt_uv_disable = OPT_FIRST[MOCFG_BIT_UV_DISABLE];
    assign opt_wdt_period = OPT_FIRST[MOCFG_BIT_WDT_PERIOD];
    assign opt_pullup_off = OPT_SECOND[MOCFG_BIT_PULLUP_OFF];

    // Static option outputs, also constants.
    assign undervoltage_enable = ~opt_uv_disable;
    assign undervoltage_trip_select = {OPT_SECOND[MOCFG_BIT_TRIP_HI],
                                       OPT_SECOND[MOCFG_BIT_TRIP_LO]};
    assign ext_int_pullup_en = ~opt_pullup_off;
    assign watchdog_active = ~opt_wdt_disable;

    ////////////////////////////////////////////////////////////////////////////
    // Stop instruction gate. A disabled stop never reaches the sequencer.
    logic next_stop_taken;
    logic next_illegal_opcode;

    always_comb begin
        next_stop_taken = 1'b0;
        next_illegal_opcode = 1'b0;
        if (stop_decode && !in_stop && !in_recover) begin
            if (opt_stop_enable) begin
                next_stop_taken = 1'b1;
            end else begin
                next_illegal_opcode = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stop_taken <= 1'b0;
            illegal_opcode <= 1'b0;
        end else begin
            stop_taken <= next_stop_taken;
            illegal_opcode <= next_illegal_opcode;
        end
    end

    // Short wake is only safe with a clock that needs no start-up time.
    logic long_used;

    mocfg_stop_seq u_stop_seq (
        .core_clk(core_clk),
        .reset(reset),
        .stop_go(stop_taken),
        .wake_irq(wake_irq),
        .wake_reset_pin(wake_reset_pin),
        .short_wake_select(opt_short_wake),
        .in_stop(in_stop),
        .in_recover(in_recover),
        .long_used(long_used),
        .wake_done(wake_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog counter. It is frozen while the clocks are stopped or recovering.
    logic [WDT_W-1:0] wdt_count;
    logic [WDT_W-1:0] next_wdt_count;
    logic [WDT_W-1:0] wdt_last;
    logic next_watchdog_reset;
    logic service_hit;

    assign service_hit = wr && (addr == MOCFG_ADDR_SERVICE);
    assign wdt_last = opt_wdt_period ? WDT_W'(WDT_SHORT - 1)
                                     : WDT_W'(WDT_LONG - 1);

    always_comb begin
        next_wdt_count = wdt_count;
        next_watchdog_reset = 1'b0;
        if (opt_wdt_disable) begin
            next_wdt_count = '0;
        end else if (watchdog_kick || service_hit) begin
            next_wdt_count = '0;
        end else if (!in_stop && !in_recover) begin
            if (wdt_count == wdt_last) begin
                next_wdt_count = '0;
                next_watchdog_reset = 1'b1;
            end else begin
                next_wdt_count = wdt_count + WDT_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wdt_count <= '0;
            watchdog_reset <= 1'b0;
        end else begin
            wdt_count <= next_wdt_count;
            watchdog_reset <= next_watchdog_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flash register forwarding. On ROM parts the two addresses stay dead.
    logic flash_ctrl_hit;
    logic flash_prot_hit;

    assign flash_ctrl_hit = FLASH_PART && (addr == MOCFG_ADDR_FLASH_CTRL);
    assign flash_prot_hit = FLASH_PART && (addr == MOCFG_ADDR_FLASH_PROT);
    assign flash_ctrl_sel = flash_ctrl_hit && (wr || rd);
    assign flash_prot_sel = flash_prot_hit && (wr || rd);

    ////////////////////////////////////////////////////////////////////////////
    // Read path. Writes to the option registers fall through untouched, since
    // their contents are parameters and nothing here stores them.
    logic [7:0] status_byte;
    logic [7:0] next_rdata;

    always_comb begin
        status_byte = MOCFG_ZERO_BYTE;
        status_byte[MOCFG_BIT_ST_STOPPED] = in_stop;
        status_byte[MOCFG_BIT_ST_RECOVER] = in_recover;
        status_byte[MOCFG_BIT_ST_WDT_RUN] = watchdog_active;
        status_byte[MOCFG_BIT_ST_LONG_USED] = long_used;
    end

    always_comb begin
        next_rdata = MOCFG_ZERO_BYTE;
        if (rd) begin
            if (addr == MOCFG_ADDR_OPT_FIRST) begin
                next_rdata = OPT_FIRST;
            end else if (addr == MOCFG_ADDR_OPT_SECOND) begin
                next_rdata = OPT_SECOND;
            end else if (addr == MOCFG_ADDR_STATUS) begin
                next_rdata = status_byte;
            end else if (flash_ctrl_hit || flash_prot_hit) begin
                next_rdata = flash_rdata;
            end
        end
    end

    // Reserved and unmapped addresses read zero; data stands for one cycle.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata <= MOCFG_ZERO_BYTE;
        end else begin
            rdata <= next_rdata;
        end
    end

endmodule // mocfg_top
`default_nettype wire

/* File: testbench/mocfg_checker.sv */
// Purpose: Port assertions for the mask option block.
// Assumes: Parameters match the bound instance.
// Notes: Helper counters mirror recovery length and watchdog timing.
`timescale 1ns/1ps
`default_nettype none
module mocfg_checker
    import mocfg_pkg::*;
#(
    parameter logic [7:0] OPT_FIRST = 8'h00, // First option byte.
    parameter logic [7:0] OPT_SECOND = 8'h00, // Second option byte.
    parameter bit FLASH_PART = 1'b0, // Flash decode.
    parameter int WDT_SHORT = 8176, // Short period.
    parameter int WDT_LONG = 262128, // Long period.
    parameter int WDT_W = 18 // Counter width.
)(
    input wire logic core_clk, // Clock.
    input wire logic reset, // Reset.
    input wire logic [15:0] addr, // Address.
    input wire logic wr, // Write.
    input wire logic rd, // Read.
    input wire logic [7:0] rdata, // Read data.
    input wire logic flash_ctrl_sel, // Select.
    input wire logic flash_prot_sel, // Select.
    input wire logic stop_decode, // Stop op.
    input wire logic stop_taken, // Accepted.
    input wire logic illegal_opcode, // Illegal.
    input wire logic wake_reset_pin, // Pin wake.
    input wire logic in_stop, // Stopped.
    input wire logic in_recover, // Recovering.
    input wire logic wake_done, // Done.
    input wire logic watchdog_kick, // Kick.
    input wire logic watchdog_active, // Active.
    input wire logic watchdog_reset, // Timeout.
    input wire logic undervoltage_enable, // Enable.
    input wire logic [1:0] undervoltage_trip_select, // Trip.
    input wire logic ext_int_pullup_en // Pull-up.
);
    localparam int WD_P = OPT_FIRST[MOCFG_BIT_WDT_PERIOD] ? WDT_SHORT : WDT_LONG;
    logic [12:0] rec_cnt;
    logic long_wake;
    logic [WDT_W-1:0] wd_cnt;
    logic wd_hit;
    logic wd_on;
    ////////////////////////////////////////////////////////////////////////////
    // The watchdog freezes while clocks are gated, so stop and recovery pause it.
    assign wd_on = !in_stop && !in_recover && !OPT_FIRST[MOCFG_BIT_WDT_DISABLE];
    // Reference counters for recovery length and watchdog timeout.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rec_cnt <= '0;
            long_wake <= 1'b0;
        end else begin
            rec_cnt <= in_recover ? rec_cnt + 13'h0001 : '0;
            long_wake <= in_stop ? wake_reset_pin : long_wake;
        end
        if (reset || watchdog_kick || (wr && addr == MOCFG_ADDR_SERVICE)) begin
            wd_cnt <= '0;
            wd_hit <= 1'b0;
        end else begin
            wd_hit <= wd_on && (wd_cnt == WDT_W'(WD_P - 1));
            if (wd_on) begin
                wd_cnt <= (wd_cnt == WDT_W'(WD_P - 1)) ? '0 : wd_cnt + 1'b1;
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////
    a_read_first: assert property (
        rd && addr == MOCFG_ADDR_OPT_FIRST |=> rdata == OPT_FIRST) else $error("bad first");
    a_read_second: assert property (
        rd && addr == MOCFG_ADDR_OPT_SECOND |=> rdata == OPT_SECOND) else $error("bad second");
    a_reserved_zero: assert property (
        rd && !FLASH_PART && (addr == MOCFG_ADDR_FLASH_CTRL || addr == MOCFG_ADDR_FLASH_PROT)
        |=> rdata == MOCFG_ZERO_BYTE) else $error("reserved read not zero");
    a_flash_select: assert property (
        flash_ctrl_sel == (FLASH_PART && (rd || wr) && addr == MOCFG_ADDR_FLASH_CTRL) &&
        flash_prot_sel == (FLASH_PART && (rd || wr) && addr == MOCFG_ADDR_FLASH_PROT))
        else $error("flash select wrong");
    a_stop_answer: assert property (
        stop_decode && !in_stop && !in_recover |=> stop_taken == OPT_FIRST[1] &&
        illegal_opcode == !OPT_FIRST[1]) else $error("stop answer wrong");
    a_stop_enter: assert property (
        stop_taken |=> in_stop) else $error("stop not entered");
    a_recover_len: assert property (
        wake_done |-> rec_cnt == ((long_wake || !OPT_FIRST[MOCFG_BIT_SHORT_WAKE]) ?
        13'h1000 : 13'h0020)) else $error("recovery length wrong");
    a_watchdog_period: assert property (
        watchdog_reset == wd_hit) else $error("watchdog timeout wrong");
    a_watchdog_gate: assert property (
        watchdog_active == !OPT_FIRST[MOCFG_BIT_WDT_DISABLE]) else $error("watchdog gate");
    a_uv_outputs: assert property (
        undervoltage_enable == !OPT_FIRST[MOCFG_BIT_UV_DISABLE] &&
        undervoltage_trip_select == OPT_SECOND[1:0]) else $error("undervoltage wrong");
    a_pullup_option: assert property (
        ext_int_pullup_en == !OPT_SECOND[MOCFG_BIT_PULLUP_OFF]) else $error("pull-up wrong");
    c_wake: cover property (wake_done);
    c_timeout: cover property (watchdog_reset);
    c_stop: cover property (stop_taken);
endmodule // mocfg_checker
bind mocfg_top mocfg_checker #(.OPT_FIRST(OPT_FIRST), .OPT_SECOND(OPT_SECOND),
    .FLASH_PART(FLASH_PART), .WDT_SHORT(WDT_SHORT), .WDT_LONG(WDT_LONG), .WDT_W(WDT_W))
    u_checker (.core_clk(core_clk), .reset(reset), .addr(addr), .wr(wr), .rd(rd),
    .rdata(rdata), .flash_ctrl_sel(flash_ctrl_sel), .flash_prot_sel(flash_prot_sel),
    .stop_decode(stop_decode), .stop_taken(stop_taken), .illegal_opcode(illegal_opcode),
    .wake_reset_pin(wake_reset_pin), .in_stop(in_stop), .in_recover(in_recover),
    .wake_done(wake_done), .watchdog_kick(watchdog_kick), .watchdog_active(watchdog_active),
    .watchdog_reset(watchdog_reset), .undervoltage_enable(undervoltage_enable),
    .undervoltage_trip_select(undervoltage_trip_select),
    .ext_int_pullup_en(ext_int_pullup_en));
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the mask option block.
// Assumes: ROM variant, both watchdog counts shortened to keep runs brief.
// Notes: Options pick short wake, legal stop and a running watchdog.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mocfg_pkg::*;
    // Short wake is set because the bench stands for a canned clock, not a crystal.
    localparam logic [7:0] OPT1 = 8'h1e;
    localparam logic [7:0] OPT2 = 8'h82;
    logic core_clk, reset, wr, rd, stop_decode, wake_irq, wake_reset_pin, watchdog_kick;
    logic [15:0] addr;
    logic [7:0] wdata, rdata;
    logic flash_ctrl_sel, flash_prot_sel, stop_taken, illegal_opcode, in_stop, in_recover;
    logic wake_done, watchdog_active, watchdog_reset, undervoltage_enable, ext_int_pullup_en;
    logic [1:0] undervoltage_trip_select;
    int n_mismatch, tests_run;
    mocfg_top #(.OPT_FIRST(OPT1), .OPT_SECOND(OPT2), .FLASH_PART(1'b0), .WDT_SHORT(20),
        .WDT_LONG(40), .WDT_W(8)) u_dut (.core_clk(core_clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .flash_ctrl_sel(flash_ctrl_sel),
        .flash_prot_sel(flash_prot_sel), .flash_rdata(8'h5a), .stop_decode(stop_decode),
        .stop_taken(stop_taken), .illegal_opcode(illegal_opcode), .wake_irq(wake_irq),
        .wake_reset_pin(wake_reset_pin), .in_stop(in_stop), .in_recover(in_recover),
        .wake_done(wake_done), .watchdog_kick(watchdog_kick),
        .watchdog_active(watchdog_active), .watchdog_reset(watchdog_reset),
        .undervoltage_enable(undervoltage_enable),
        .undervoltage_trip_select(undervoltage_trip_select),
        .ext_int_pullup_en(ext_int_pullup_en));
    // Free-running 25 MHz clock.
    always #20 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Read one byte; the flash selects must stay low on a ROM part.
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        #1 check({14'h0000, flash_ctrl_sel, flash_prot_sel}, 16'h0000);
        @(posedge core_clk);
        rd <= 1'b0;
        #1 check({8'h00, rdata}, {8'h00, e});
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Writes must not disturb the wired bytes; reserved and unmapped read zero.
    task automatic reg_scenario;
        rd_reg(MOCFG_ADDR_STATUS, 8'h04);
        rd_reg(MOCFG_ADDR_OPT_FIRST, OPT1);
        wr_reg(MOCFG_ADDR_OPT_FIRST, 8'he1);
        wr_reg(MOCFG_ADDR_OPT_SECOND, 8'h7d);
        rd_reg(MOCFG_ADDR_OPT_FIRST, OPT1);
        rd_reg(MOCFG_ADDR_OPT_SECOND, OPT2);
        rd_reg(MOCFG_ADDR_FLASH_CTRL, 8'h00);
        rd_reg(MOCFG_ADDR_FLASH_PROT, 8'h00);
        rd_reg(16'h1234, 8'h00);
    endtask
    task automatic const_scenario;
        check({15'h0000, watchdog_active}, 16'h0001);
        check({15'h0000, undervoltage_enable}, 16'h0000);
        check({14'h0000, undervoltage_trip_select}, 16'h0002);
        check({15'h0000, ext_int_pullup_en}, 16'h0000);
    endtask
    // Enter stop, wake by interrupt or by the reset pin (both high: the pin wins).
    task automatic stop_scenario(input bit by_pin, input logic [15:0] exp_len);
        logic [15:0] n;
        n = 16'h0000;
        @(posedge core_clk);
        stop_decode <= 1'b1;
        @(posedge core_clk);
        stop_decode <= 1'b0;
        #1 check({15'h0000, stop_taken}, 16'h0001);
        check({15'h0000, illegal_opcode}, 16'h0000);
        @(posedge core_clk);
        #1 check({15'h0000, in_stop}, 16'h0001);
        repeat (3) @(posedge core_clk);
        wake_irq <= 1'b1;
        wake_reset_pin <= by_pin;
        @(posedge core_clk);
        wake_irq <= 1'b0;
        wake_reset_pin <= 1'b0;
        #1;
        while (in_recover === 1'b1 && n < 16'h1400) begin
            n++;
            @(posedge core_clk);
            #1;
        end
        if (n >= 16'h1400) begin
            n_mismatch++;
            test_done();
        end
        check(n, exp_len);
        check({15'h0000, wake_done}, 16'h0001);
    endtask
    // After a kick or a service write the timeout comes exactly one short period later.
    task automatic wdt_scenario(input bit by_write);
        logic [15:0] n;
        n = 16'h0000;
        if (by_write) begin
            wr_reg(MOCFG_ADDR_SERVICE, 8'h00);
        end else begin
            @(posedge core_clk);
            watchdog_kick <= 1'b1;
            @(posedge core_clk);
            watchdog_kick <= 1'b0;
        end
        #1;
        while (watchdog_reset !== 1'b1 && n < 16'h00c8) begin
            @(posedge core_clk);
            n++;
            #1;
        end
        check(n, 16'h0014);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        addr = 16'h0000;
        wdata = 8'h00;
        {wr, rd, stop_decode, wake_irq, wake_reset_pin, watchdog_kick} = 6'h00;
        n_mismatch = 0;
        tests_run = 0;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        reg_scenario();
        const_scenario();
        stop_scenario(1'b0, 16'h0020);
        stop_scenario(1'b1, 16'h1000);
        rd_reg(MOCFG_ADDR_STATUS, 8'h0c);
        wdt_scenario(1'b0);
        wdt_scenario(1'b1);
        test_done();
    end
endmodule // tb_top
`default_nettype wire
